// *** core/pcc_defs.vh ***
`ifndef PCC_DEFS_VH
`define PCC_DEFS_VH

// ==========================================================================
// register byte addresses
`define PCC_ADDR_CTRL      32'h02310100
`define PCC_ADDR_STATUS    32'h02310104
`define PCC_ADDR_POSTDIV   32'h02310108
`define PCC_ADDR_MAINCFG   32'h0231010C
`define PCC_ADDR_SPEED     32'h02310110
`define PCC_ADDR_MAINCTL1  32'h0262032C
`define PCC_ADDR_MEMCTL1   32'h0262033C
`define PCC_ADDR_PECTL1    32'h02620354

// ==========================================================================
// field positions
`define PCC_CTRL_PATH_EN   0
`define PCC_CTRL_RESET     1
`define PCC_CTRL_ENSRC     5
`define PCC_POSTDIV_HI     22
`define PCC_POSTDIV_LO     19
`define PCC_POSTDIV_DIV2   4'h1
`define PCC_MULT_HI        12
`define PCC_MULT_LO        0
`define PCC_DIV_HI         21
`define PCC_DIV_LO         16
`define PCC_SAT_BIT        6
`define PCC_LOOP_BW_HI     3
`define PCC_LOOP_BW_LO     0
`define PCC_OFFLOAD_SEL    13
`define PCC_ST_LOCK        0
`define PCC_ST_BYPASS      1
`define PCC_ST_OFFLOAD     2
`define PCC_ST_REFUSED     3
`define PCC_ST_SPEED_LO    4

// ==========================================================================
// reset values and boot multipliers for a 100 MHz reference, divide by two
`define PCC_RST_WORD       32'h00000000
`define PCC_BOOT_MULT_800  13'h000F
`define PCC_BOOT_MULT_1000 13'h0013
`define PCC_BOOT_MULT_1200 13'h0017

// ==========================================================================
// timing
`define PCC_LOCK_TIME_US   10
`define PCC_CLK_MHZ        125
`endif

// *** core/pcc_offload_sel.v ***
module pcc_offload_sel (
    input  wire pclk,
    input  wire presetn,
    input  wire sel,
    input  wire tick_sys,
    input  wire tick_pe,
    output reg  tick_out,
    output reg  cur_src
);
    // ======================================================================
    // switch only at period boundaries of both sources
    localparam RUN       = 2'b00;
    localparam WAIT_OLD  = 2'b01;
    localparam WAIT_NEW  = 2'b10;

    reg  [1:0] state;
    wire       old_tick = cur_src ? tick_pe : tick_sys;
    wire       new_tick = cur_src ? tick_sys : tick_pe;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= RUN;
            cur_src  <= 1'b0;
            tick_out <= 1'b0;
        end else begin
            tick_out <= 1'b0;
            case (state)
                RUN: begin
                    tick_out <= old_tick;
                    if (sel != cur_src)
                        state <= WAIT_OLD;
                end
                WAIT_OLD: begin
                    // finish the running period before letting go
                    tick_out <= old_tick;
                    if (old_tick)
                        state <= WAIT_NEW;
                end
                WAIT_NEW: begin
                    // first new edge only aligns; a partial period is never passed
                    if (new_tick) begin
                        cur_src <= ~cur_src;
                        state   <= RUN;
                    end
                end
                default: state <= RUN;
            endcase
        end
    end
endmodule // pcc_offload_sel

// *** core/pcc_top.v ***
`include "pcc_defs.vh"

module pcc_top #(
    parameter MULT_W      = 13,
    parameter DIV_W       = 6,
    parameter ACC_W       = 24,
    parameter LOCK_CYCLES = `PCC_LOCK_TIME_US * `PCC_CLK_MHZ
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [1:0]  speed_grade,
    input  wire        ref_tick,
    input  wire        pe_pll_tick,
    output reg         main_clk_tick,
    output reg         offload_tick,
    output reg         pll_bypass,
    output reg         main_saturation_enable,
    output reg         mem_saturation_enable,
    output reg         pe_saturation_enable
);
    // ======================================================================
    // storage
    reg  [31:0]       ctrl_reg;
    reg  [31:0]       pll_post_divider_control;
    reg  [31:0]       main_cfg_reg;
    reg  [31:0]       main_pll_control_one;
    reg  [31:0]       memory_pll_control_one;
    reg  [31:0]       packet_engine_pll_control_one;
    reg  [1:0]        speed_grade_register;
    reg               boot_done;
    reg               boot_settle;
    reg               refused;
    reg  [15:0]       lock_cnt;
    reg               locked;
    reg  [MULT_W-1:0] act_mult;
    reg  [DIV_W-1:0]  act_div;
    reg  [3:0]        act_post;
    reg  [ACC_W-1:0]  acc;
    reg               pll_tick;
    reg  [31:0]       next_rdata;
    reg               next_err;

    wire [31:0]       lock_full   = LOCK_CYCLES;
    wire [15:0]       lock_target = lock_full[15:0];
    wire              xfer_done   = psel & penable & pready;
    wire              wr_en       = xfer_done & pwrite;
    wire              path_en     = ctrl_reg[`PCC_CTRL_PATH_EN];
    wire              ensrc       = ctrl_reg[`PCC_CTRL_ENSRC];
    wire              pll_rst     = ctrl_reg[`PCC_CTRL_RESET];
    // pll routed only when enabled by either source and locked
    wire              route_pll   = (path_en | ensrc) & locked;
    wire              in_bypass   = ~(path_en | ensrc);
    wire              offload_src;
    wire              sel_tick;

    // ======================================================================
    // address decode, shared by read and write paths
    function [3:0] reg_index;
        input [31:0] a;
        begin
            case (a)
                `PCC_ADDR_CTRL:     reg_index = 4'h1;
                `PCC_ADDR_STATUS:   reg_index = 4'h2;
                `PCC_ADDR_POSTDIV:  reg_index = 4'h3;
                `PCC_ADDR_MAINCFG:  reg_index = 4'h4;
                `PCC_ADDR_SPEED:    reg_index = 4'h5;
                `PCC_ADDR_MAINCTL1: reg_index = 4'h6;
                `PCC_ADDR_MEMCTL1:  reg_index = 4'h7;
                `PCC_ADDR_PECTL1:   reg_index = 4'h8;
                default:            reg_index = 4'h0;
            endcase
        end
    endfunction

    // config writes are refused unless path_en and ensrc are both clear
    wire cfg_addr  = (reg_index(paddr) == 4'h3) | (reg_index(paddr) == 4'h4)
                     | (reg_index(paddr) == 4'h6);
    wire cfg_write = wr_en & cfg_addr;

    // ======================================================================
    // apb slave: one wait state, answer registered
    always @* begin
        next_rdata = 32'h00000000;
        next_err   = 1'b0;
        case (reg_index(paddr))
            4'h1: next_rdata = ctrl_reg;
            4'h2: next_rdata = {26'h0000000, speed_grade_register, refused,
                                offload_src, pll_bypass, locked};
            4'h3: next_rdata = pll_post_divider_control;
            4'h4: next_rdata = main_cfg_reg;
            4'h5: next_rdata = {30'h00000000, speed_grade_register};
            4'h6: next_rdata = main_pll_control_one;
            4'h7: next_rdata = memory_pll_control_one;
            4'h8: next_rdata = packet_engine_pll_control_one;
            default: next_err = 1'b1;
        endcase
        // error is decided in the first access cycle, before pready rises
        if (pwrite & cfg_addr & ~in_bypass)
            next_err = 1'b1;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & next_err;
            if (psel & penable & ~pready & ~pwrite)
                prdata <= next_rdata;
        end
    end

    // ======================================================================
    // register writes; boot values taken once after reset release
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg                      <= `PCC_RST_WORD;
            pll_post_divider_control      <= `PCC_RST_WORD;
            main_cfg_reg                  <= `PCC_RST_WORD;
            main_pll_control_one          <= `PCC_RST_WORD;
            memory_pll_control_one        <= `PCC_RST_WORD;
            packet_engine_pll_control_one <= `PCC_RST_WORD;
            speed_grade_register          <= 2'h0;
            boot_done                     <= 1'b0;
            refused                       <= 1'b0;
        end else if (!boot_done) begin
            // boot setting picked from speed grade; faster parts need software
            boot_done            <= 1'b1;
            speed_grade_register <= speed_grade;
            pll_post_divider_control[`PCC_POSTDIV_HI:`PCC_POSTDIV_LO] <= `PCC_POSTDIV_DIV2;
            ctrl_reg[`PCC_CTRL_PATH_EN] <= 1'b1;
            case (speed_grade)
                2'h0:    main_cfg_reg[`PCC_MULT_HI:`PCC_MULT_LO] <= `PCC_BOOT_MULT_800;
                2'h1:    main_cfg_reg[`PCC_MULT_HI:`PCC_MULT_LO] <= `PCC_BOOT_MULT_1000;
                default: main_cfg_reg[`PCC_MULT_HI:`PCC_MULT_LO] <= `PCC_BOOT_MULT_1200;
            endcase
        end else if (wr_en) begin
            if (cfg_write & ~in_bypass) begin
                refused <= 1'b1;
            end else begin
                case (reg_index(paddr))
                    4'h1: begin
                        ctrl_reg <= pwdata;
                        refused  <= 1'b0;
                    end
                    4'h3: pll_post_divider_control      <= pwdata;
                    4'h4: main_cfg_reg                  <= pwdata;
                    4'h6: main_pll_control_one          <= pwdata;
                    4'h7: memory_pll_control_one        <= pwdata;
                    4'h8: packet_engine_pll_control_one <= pwdata;
                    default: refused <= refused;
                endcase
            end
        end
    end

    // ======================================================================
    // pll model: settings latched while reset is asserted, then lock timer
    // boot fields land one edge after release, so the latch waits one more
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            boot_settle <= 1'b0;
        else
            boot_settle <= boot_done;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_mult <= {MULT_W{1'b0}};
            act_div  <= {DIV_W{1'b0}};
            act_post <= 4'h0;
            lock_cnt <= 16'h0000;
            locked   <= 1'b0;
        end else if (pll_rst | ~boot_settle) begin
            // fields are sampled every cycle while reset is asserted; the values at release are used
            act_mult <= main_cfg_reg[`PCC_MULT_HI:`PCC_MULT_LO];
            act_div  <= main_cfg_reg[`PCC_DIV_HI:`PCC_DIV_LO];
            act_post <= pll_post_divider_control[`PCC_POSTDIV_HI:`PCC_POSTDIV_LO];
            lock_cnt <= 16'h0000;
            locked   <= 1'b0;
        end else if (!locked) begin
            lock_cnt <= lock_cnt + 16'h0001;
            if (lock_cnt + 16'h0001 >= lock_target)
                locked <= 1'b1;
        end
    end

    // ======================================================================
    // rate generator: ref * (m+1) / ((post+1) * (d+1)); post code 1 halves it
    wire [ACC_W-1:0] step = ref_tick ? {{(ACC_W-MULT_W){1'b0}}, act_mult}
                                       + {{(ACC_W-1){1'b0}}, 1'b1}
                                     : {ACC_W{1'b0}};
    wire [ACC_W-1:0] den  = ({{(ACC_W-4){1'b0}}, act_post} + {{(ACC_W-1){1'b0}}, 1'b1})
                          * ({{(ACC_W-DIV_W){1'b0}}, act_div} + {{(ACC_W-1){1'b0}}, 1'b1});
    wire [ACC_W-1:0] sum  = acc + step;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc      <= {ACC_W{1'b0}};
            pll_tick <= 1'b0;
        end else if (!locked) begin
            acc      <= {ACC_W{1'b0}};
            pll_tick <= 1'b0;
        end else if (sum >= den) begin
            // at most one pulse per pclk; bursts above pclk rate are spread out
            acc      <= sum - den;
            pll_tick <= 1'b1;
        end else begin
            acc      <= sum;
            pll_tick <= 1'b0;
        end
    end

    // ======================================================================
    // output mux and side outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_clk_tick          <= 1'b0;
            pll_bypass             <= 1'b1;
            offload_tick           <= 1'b0;
            main_saturation_enable <= 1'b0;
            mem_saturation_enable  <= 1'b0;
            pe_saturation_enable   <= 1'b0;
        end else begin
            main_clk_tick          <= route_pll ? pll_tick : ref_tick;
            pll_bypass             <= ~route_pll;
            offload_tick           <= sel_tick;
            main_saturation_enable <= main_pll_control_one[`PCC_SAT_BIT];
            mem_saturation_enable  <= memory_pll_control_one[`PCC_SAT_BIT];
            pe_saturation_enable   <= packet_engine_pll_control_one[`PCC_SAT_BIT];
        end
    end

    // system clock one is the main output tick
    pcc_offload_sel u_offload_sel (
        .pclk     (pclk),
        .presetn  (presetn),
        .sel      (packet_engine_pll_control_one[`PCC_OFFLOAD_SEL]),
        .tick_sys (main_clk_tick),
        .tick_pe  (pe_pll_tick),
        .tick_out (sel_tick),
        .cur_src  (offload_src)
    );
endmodule // pcc_top

// *** bench/pcc_top_sva.sv ***
`include "pcc_defs.vh"
module pcc_top_sva #(
    parameter LOCK_CYCLES = 1250
) (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [1:0]  speed_grade,
    input wire        ref_tick,
    input wire        pe_pll_tick,
    input wire        main_clk_tick,
    input wire        offload_tick,
    input wire        pll_bypass,
    input wire        main_saturation_enable,
    input wire        mem_saturation_enable,
    input wire        pe_saturation_enable
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ======================================
    // helper state
    wire       taken = psel && penable && pready;
    reg [31:0] byp_cnt;
    reg [3:0]  since_rst;
    reg        pe_written;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byp_cnt    <= 32'h0;
            since_rst  <= 4'h0;
            pe_written <= 1'b0;
        end else begin
            byp_cnt <= pll_bypass ? byp_cnt + 32'h1 : 32'h0;
            if (since_rst != 4'hF) since_rst <= since_rst + 4'h1;
            if (taken && pwrite && paddr == `PCC_ADDR_PECTL1) pe_written <= 1'b1;
        end
    end
    sequence s_access;
        psel && !penable ##1 psel && penable;
    endsequence
    sequence s_ctl_write;
        taken && pwrite && paddr == `PCC_ADDR_MAINCTL1;
    endsequence
    // ======================================
    // assertions
    chk_ready_wait: assert property (s_access |-> !pready ##1 pready)
        else $error("access phase not one wait state");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_bypass_lock: assert property ($fell(pll_bypass) |-> byp_cnt >= LOCK_CYCLES)
        else $error("bypass left before lock time");
    chk_bypass_pass: assert property (pll_bypass && $past(pll_bypass) && $past(pll_bypass, 2)
        |-> main_clk_tick == $past(ref_tick)) else $error("bypass not passing ref");
    chk_sat_write: assert property (s_ctl_write ##0 !pslverr
        |=> ##1 main_saturation_enable == $past(pwdata[6], 2)) else $error("sat bit not written");
    chk_refused_hold: assert property (s_ctl_write ##0 pslverr
        |=> ##1 $stable(main_saturation_enable)) else $error("refused write changed sat bit");
    chk_offload_default: assert property (since_rst > 4'h4 && !pe_written
        |-> offload_tick == $past(main_clk_tick, 2)) else $error("offload not on sys clock");
    chk_offload_src: assert property (offload_tick |-> $past(main_clk_tick, 2)
        || $past(pe_pll_tick) || $past(pe_pll_tick, 2) || $past(pe_pll_tick, 3))
        else $error("offload pulse without source");
endmodule // pcc_top_sva

bind pcc_top pcc_top_sva #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .speed_grade(speed_grade), .ref_tick(ref_tick), .pe_pll_tick(pe_pll_tick),
    .main_clk_tick(main_clk_tick), .offload_tick(offload_tick), .pll_bypass(pll_bypass),
    .main_saturation_enable(main_saturation_enable),
    .mem_saturation_enable(mem_saturation_enable),
    .pe_saturation_enable(pe_saturation_enable));

// *** bench/testbench.sv ***
`include "pcc_defs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LOCK = 8;
    reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    reg         ref_tick = 0, pe_pll_tick = 0, err;
    reg  [31:0] paddr = 0, pwdata = 0, rd, w;
    reg  [1:0]  speed_grade = 0;
    wire [31:0] prdata;
    wire        pready, pslverr, main_clk_tick, offload_tick, pll_bypass;
    wire [2:0]  sat;
    integer     seed = 32'h32edcbcd, fails = 0, tests_run = 0, cycles = 0;
    integer     n_main = 0, n_off = 0, n_pe = 0, g, m, d, e, a0, b0;
    reg  [31:0] sat_addr [3] = '{`PCC_ADDR_MAINCTL1, `PCC_ADDR_MEMCTL1, `PCC_ADDR_PECTL1};

    pcc_top #(.LOCK_CYCLES(LOCK)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .speed_grade(speed_grade), .ref_tick(ref_tick), .pe_pll_tick(pe_pll_tick),
        .main_clk_tick(main_clk_tick), .offload_tick(offload_tick), .pll_bypass(pll_bypass),
        .main_saturation_enable(sat[0]), .mem_saturation_enable(sat[1]),
        .pe_saturation_enable(sat[2]));

    initial forever #4 pclk = ~pclk;
    // ======================================
    // tick sources, counters, hang guard
    always @(posedge pclk) begin
        cycles = cycles + 1;
        n_main = n_main + main_clk_tick;
        n_off  = n_off + offload_tick;
        n_pe   = n_pe + pe_pll_tick;
        ref_tick    <= presetn;
        pe_pll_tick <= presetn && (($random(seed) & 3) == 0);
        if (cycles >= 30000) begin
            fails = fails + 1;
            results;
        end
    end
    // ======================================
    // compare and bus tasks
    task check32(input string nm, input [31:0] exp, input [31:0] got);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task check1(input string nm, input logic exp, input logic got);
        check32(nm, {31'h0, exp}, {31'h0, got});
    endtask
    function logic near(input integer got, input integer exp);
        return (got - exp <= 1) && (exp - got <= 1);
    endfunction
    function [31:0] boot_mult(input [1:0] sg);
        return sg == 0 ? `PCC_BOOT_MULT_800 : sg == 1 ? `PCC_BOOT_MULT_1000 : `PCC_BOOT_MULT_1200;
    endfunction
    task apb(input logic wr, input [31:0] a, input [31:0] dd);
        integer k;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= dd;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        // no local limit: only the cycle ceiling ends a hung transfer
        do begin
            @(posedge pclk);
            k = k + 1;
        end while (pready !== 1'b1);
        check1("pready", 1'b1, pready);
        check32("wait_cycles", 32'h2, k);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task do_reset(input [1:0] sg);
        @(posedge pclk);
        presetn <= 0;
        speed_grade <= sg;
        repeat (12) @(posedge pclk);
        presetn <= 1;
    endtask
    task wait_lock;
        integer k;
        k = 0;
        while (pll_bypass !== 1'b0 && k < LOCK * 4 + 50) begin
            @(posedge pclk);
            k = k + 1;
        end
        check1("pll_bypass", 1'b0, pll_bypass);
    endtask
    task results;
        if (fails == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ======================================
    // main sequence
    initial begin
        for (g = 0; g < 4; g = g + 1) begin
            do_reset(g[1:0]);
            check1("bypass_boot", 1'b1, pll_bypass);
            apb(0, `PCC_ADDR_MAINCFG, 0); check32("boot_mult", boot_mult(g[1:0]), rd);
            apb(0, `PCC_ADDR_STATUS, 0); check32("speed", g, {30'h0, rd[5:4]});
            apb(0, `PCC_ADDR_POSTDIV, 0); check32("post_boot", 32'h1, {28'h0, rd[22:19]});
            apb(0, `PCC_ADDR_PECTL1, 0); check1("offload_rst", 1'b0, rd[13]);
            wait_lock;
        end
        // config writes refused while the path is live; corner before any bypass
        apb(1, `PCC_ADDR_MAINCFG, 32'h00030001); check1("refused", 1'b1, err);
        apb(0, `PCC_ADDR_STATUS, 0); check1("refused_flag", 1'b1, rd[3]);
        apb(0, `PCC_ADDR_MAINCFG, 0); check32("cfg_kept", boot_mult(3), rd);
        apb(0, 32'h02310114, 0); check1("unmapped_err", 1'b1, err);
        check32("unmapped_data", 32'h0, rd);
        repeat (3) begin
            d = 3 + ($random(seed) & 3);
            m = {$random(seed)} % (d + 1);
            apb(1, `PCC_ADDR_CTRL, 0);
            apb(0, `PCC_ADDR_STATUS, 0); check1("bypass_on", 1'b1, rd[1]);
            apb(1, `PCC_ADDR_MAINCFG, {10'h0, d[5:0], 3'h0, m[12:0]});
            check1("cfg_accept", 1'b0, err);
            apb(0, `PCC_ADDR_POSTDIV, 0);
            w = rd;
            w[22:19] = `PCC_POSTDIV_DIV2;
            apb(1, `PCC_ADDR_POSTDIV, w);
            apb(0, `PCC_ADDR_POSTDIV, 0); check32("post_rmw", w, rd);
            apb(1, `PCC_ADDR_CTRL, 32'h2);
            apb(1, `PCC_ADDR_CTRL, 32'h1);
            repeat (2) @(posedge pclk);
            check1("bypass_hold", 1'b1, pll_bypass);
            wait_lock;
            repeat (4) @(posedge pclk);
            a0 = n_main;
            repeat (400) @(posedge pclk);
            e = 400 * (m + 1) / (2 * (d + 1));
            check1("main_rate", 1'b1, near(n_main - a0, e));
        end
        // main saturation bit only writable in bypass; mem and pe bits always writable
        apb(1, `PCC_ADDR_CTRL, 0);
        for (g = 0; g < 6; g = g + 1) begin
            apb(1, sat_addr[g % 3], {25'h0, g[0], 6'h0});
            repeat (2) @(posedge pclk);
            check1("sat_bit", g[0], sat[g % 3]);
        end
        apb(1, `PCC_ADDR_CTRL, 32'h1);
        apb(1, `PCC_ADDR_MAINCTL1, 0); check1("sat_refused", 1'b1, err);
        repeat (2) @(posedge pclk);
        check1("sat_kept", 1'b1, sat[0]);
        // offload source switch both ways; settled pulse count matches the new source within one
        for (g = 1; g >= 0; g = g - 1) begin
            apb(1, `PCC_ADDR_PECTL1, {18'h0, g[0], 13'h0});
            repeat (100) @(posedge pclk);
            apb(0, `PCC_ADDR_STATUS, 0); check1("offload_src", g[0], rd[2]);
            // offload trails its source by two edges; windows shifted to match
            b0 = g ? n_pe : n_main;
            repeat (2) @(posedge pclk);
            a0 = n_off;
            repeat (298) @(posedge pclk);
            e = (g ? n_pe : n_main) - b0;
            repeat (2) @(posedge pclk);
            check1("offload_rate", 1'b1, near(n_off - a0, e));
        end
        results;
    end
endmodule // testbench
